// ### hw/cpt_apb_slave.sv
// Zero-wait APB slave front end for the timing override registers
`timescale 1ns/1ps
`default_nettype none
`include "cpt_consts.svh"

module cpt_apb_slave
  import cpt_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CPT_ADDR_W-1:0] paddr,
  input  wire logic [`CPT_DATA_W-1:0] pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [`CPT_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  cpt_regbus_if.bus                   rb
);

  logic [`CPT_DATA_W-1:0] prdata_r;
  logic [`CPT_DATA_W-1:0] prdata_nxt;

  // ==========================================================
  // Address decode; anything else answers with an error
  always_comb begin
    if (paddr == `CPT_ADDR_HS_EXIT) begin
      rb.sel = CPT_SEL_HS;
    end else if (paddr == `CPT_ADDR_PLX) begin
      rb.sel = CPT_SEL_PLX;
    end else begin
      rb.sel = CPT_SEL_NONE;
    end
  end

  // Never stalls, so every access phase ends on its first edge
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & (rb.sel == CPT_SEL_NONE);
  // Only lane 0 carries register bits; other lanes are ignored
  assign rb.wr_en = psel & penable & pwrite & pstrb[0] & (rb.sel != CPT_SEL_NONE);
  assign rb.wdata = pwdata[`CPT_REG_W-1:0];

  // ==========================================================
  // Read data captured in setup so it leaves a flop in access
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = {{(`CPT_DATA_W-`CPT_REG_W){1'b0}}, rb.rdata};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= `CPT_RST_RDATA;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule // cpt_apb_slave

`default_nettype wire

// ### hw/cpt_timing_field.sv
// One override bit plus a 7-bit timing value with auto readback
`timescale 1ns/1ps
`default_nettype none
`include "cpt_consts.svh"

module cpt_timing_field
  import cpt_pkg::*;
#(
  parameter cpt_val_t RST_VAL = `CPT_RST_HS_VAL
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      wr_en,
  input  wire cpt_byte_t wdata,
  input  wire cpt_val_t  auto_val,
  output logic           override_en,
  output cpt_val_t       value,
  output cpt_byte_t      rd_byte
);

  logic     ov_r;
  logic     ov_nxt;
  cpt_val_t val_r;
  cpt_val_t val_nxt;

  // ==========================================================
  // Value only loads when the same write sets the override bit
  always_comb begin
    ov_nxt  = ov_r;
    val_nxt = val_r;
    if (wr_en) begin
      ov_nxt = wdata[`CPT_OV_BIT];
      if (wdata[`CPT_OV_BIT]) begin
        val_nxt = wdata[`CPT_VAL_MSB:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ov_r  <= `CPT_RST_OV;
      val_r <= RST_VAL;
    end else begin
      ov_r  <= ov_nxt;
      val_r <= val_nxt;
    end
  end

  assign override_en = ov_r;
  assign value       = val_r;
  // Auto mode shows the live computed value, not the stored one
  assign rd_byte     = {ov_r, ov_r ? val_r : auto_val};

endmodule // cpt_timing_field

`default_nettype wire

// ### hw/cpt_timing_regs.sv
// CSI port 0 timing override registers: exit and Tplx intervals
`timescale 1ns/1ps
`default_nettype none
`include "cpt_consts.svh"

// Contract
// - Exit override clear: use automatic exit interval
// - Exit override set: use programmed exit value
// - Exit override clear: field reads auto, value kept on writes that leave the bit clear
// - Exit override set: field writable, reads back
// - Tplx interval auto or programmed per override
// - Tplx override clear: field reads auto value
module cpt_timing_regs
  import cpt_pkg::*;
(
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`CPT_ADDR_W-1:0] PADDR,
  input  wire logic [`CPT_DATA_W-1:0] PWDATA,
  input  wire logic [3:0]             PSTRB,
  output logic      [`CPT_DATA_W-1:0] PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire cpt_val_t               AUTO_HS_EXIT,
  input  wire cpt_val_t               AUTO_PLX,
  input  wire logic                   HS_BURST,
  output cpt_val_t                    HS_EXIT_APPLIED,
  output cpt_val_t                    PLX_APPLIED
);

  // ==========================================================
  // Declarations
  cpt_regbus_if rb ();

  logic      hs_exit_override_en;
  cpt_val_t  hs_exit_value;
  cpt_byte_t hs_rd_byte;
  logic      plx_override_en;
  cpt_val_t  plx_value;
  cpt_byte_t plx_rd_byte;
  logic      hs_wr;
  logic      plx_wr;

  cpt_val_t  hs_applied_r;
  cpt_val_t  hs_applied_nxt;
  cpt_val_t  plx_applied_r;
  cpt_val_t  plx_applied_nxt;

  // ==========================================================
  // Bus slave
  cpt_apb_slave u_apb (
    .clk     (SYS_CLK),
    .rst     (RST),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .pstrb   (PSTRB),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .rb      (rb.bus)
  );

  // Per-register write strobes
  assign hs_wr  = rb.wr_en & (rb.sel == CPT_SEL_HS);
  assign plx_wr = rb.wr_en & (rb.sel == CPT_SEL_PLX);

  // ==========================================================
  // Register fields
  cpt_timing_field #(
    .RST_VAL (`CPT_RST_HS_VAL)
  ) u_hs_exit (
    .clk         (SYS_CLK),
    .rst         (RST),
    .wr_en       (hs_wr),
    .wdata       (rb.wdata),
    .auto_val    (AUTO_HS_EXIT),
    .override_en (hs_exit_override_en),
    .value       (hs_exit_value),
    .rd_byte     (hs_rd_byte)
  );

  cpt_timing_field #(
    .RST_VAL (`CPT_RST_PLX_VAL)
  ) u_plx (
    .clk         (SYS_CLK),
    .rst         (RST),
    .wr_en       (plx_wr),
    .wdata       (rb.wdata),
    .auto_val    (AUTO_PLX),
    .override_en (plx_override_en),
    .value       (plx_value),
    .rd_byte     (plx_rd_byte)
  );

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    case (rb.sel)
      CPT_SEL_HS:  rb.rdata = hs_rd_byte;
      CPT_SEL_PLX: rb.rdata = plx_rd_byte;
      default:     rb.rdata = '0;
    endcase
  end

  // ==========================================================
  // Applied intervals: retaken only while the lane is idle, so a
  // register change never alters a burst already under way
  always_comb begin
    hs_applied_nxt  = hs_applied_r;
    plx_applied_nxt = plx_applied_r;
    if (!HS_BURST) begin
      hs_applied_nxt  = hs_exit_override_en ? hs_exit_value : AUTO_HS_EXIT;
      plx_applied_nxt = plx_override_en ? plx_value : AUTO_PLX;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hs_applied_r  <= `CPT_RST_HS_VAL;
      plx_applied_r <= `CPT_RST_PLX_VAL;
    end else begin
      hs_applied_r  <= hs_applied_nxt;
      plx_applied_r <= plx_applied_nxt;
    end
  end

  assign HS_EXIT_APPLIED = hs_applied_r;
  assign PLX_APPLIED     = plx_applied_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // The applied-interval checks also gate on RST: at the release edge the flops still reset

  // Helper decode, seen only by the checks
  logic chk_hs_addr;
  logic chk_plx_addr;
  logic chk_setup_rd;
  logic chk_access_wr;
  assign chk_hs_addr   = (PADDR == `CPT_ADDR_HS_EXIT);
  assign chk_plx_addr  = (PADDR == `CPT_ADDR_PLX);
  assign chk_setup_rd  = PSEL && !PENABLE && !PWRITE;
  assign chk_access_wr = PSEL && PENABLE && PWRITE && PSTRB[0];

  // Idle lane in auto mode follows the computed exit interval
  property p_hs_auto;
    !RST && !hs_exit_override_en && !HS_BURST |=> HS_EXIT_APPLIED == $past(AUTO_HS_EXIT);
  endproperty
  a_hs_auto: assert property (p_hs_auto)
    else $error("exit interval not taken from auto value");

  // Idle lane in override mode uses the programmed exit value
  property p_hs_override;
    !RST && hs_exit_override_en && !HS_BURST |=> HS_EXIT_APPLIED == $past(hs_exit_value);
  endproperty
  a_hs_override: assert property (p_hs_override)
    else $error("exit interval not taken from programmed value");

  // Write without the override bit leaves the stored value alone
  property p_hs_ro_write;
    chk_access_wr && chk_hs_addr && !PWDATA[`CPT_OV_BIT] |=> $stable(hs_exit_value);
  endproperty
  a_hs_ro_write: assert property (p_hs_ro_write)
    else $error("exit value changed by write with override clear");

  // Read in auto mode returns the computed value one edge later
  sequence s_hs_auto_read;
    chk_setup_rd && chk_hs_addr && !hs_exit_override_en;
  endsequence
  property p_hs_ro_read;
    s_hs_auto_read |=> PRDATA[`CPT_VAL_MSB:0] == $past(AUTO_HS_EXIT) && !PRDATA[`CPT_OV_BIT];
  endproperty
  a_hs_ro_read: assert property (p_hs_ro_read)
    else $error("exit field read does not show auto value");

  // Override write lands in both the bit and the stored value
  sequence s_hs_ov_write;
    chk_access_wr && chk_hs_addr && PWDATA[`CPT_OV_BIT];
  endsequence
  property p_hs_rw;
    cpt_val_t v;
    (s_hs_ov_write, v = PWDATA[`CPT_VAL_MSB:0])
      |=> hs_exit_override_en && hs_exit_value == v;
  endproperty
  a_hs_rw: assert property (p_hs_rw)
    else $error("exit field write not stored");

  // With the override set, a read returns the stored value
  sequence s_hs_ov_read;
    chk_setup_rd && chk_hs_addr && hs_exit_override_en;
  endsequence
  property p_hs_rw_read;
    s_hs_ov_read |=> PRDATA == {{(`CPT_DATA_W-`CPT_REG_W){1'b0}}, 1'b1, $past(hs_exit_value)};
  endproperty
  a_hs_rw_read: assert property (p_hs_rw_read)
    else $error("exit field write not read back");

  // Tplx applied value selected by its override bit
  property p_plx_select;
    !RST && !HS_BURST |=> PLX_APPLIED == ($past(plx_override_en) ? $past(plx_value) : $past(AUTO_PLX));
  endproperty
  a_plx_select: assert property (p_plx_select)
    else $error("Tplx interval source wrong");

  // Tplx override write stores the value it carries
  property p_plx_write;
    chk_access_wr && chk_plx_addr && PWDATA[`CPT_OV_BIT]
      |=> plx_override_en && plx_value == $past(PWDATA[`CPT_VAL_MSB:0]);
  endproperty
  a_plx_write: assert property (p_plx_write)
    else $error("Tplx override write not stored");

  // Tplx read in auto mode returns the computed value
  property p_plx_auto_read;
    chk_setup_rd && chk_plx_addr && !plx_override_en
      |=> PRDATA == {{(`CPT_DATA_W-`CPT_VAL_W){1'b0}}, $past(AUTO_PLX)};
  endproperty
  a_plx_auto_read: assert property (p_plx_auto_read)
    else $error("Tplx field read does not show auto value");

  // Inside a burst both applied intervals hold still
  sequence s_burst_pair;
    HS_BURST ##1 HS_BURST;
  endsequence
  property p_burst_hold;
    s_burst_pair |-> $stable(HS_EXIT_APPLIED) && $stable(PLX_APPLIED);
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("applied interval changed during burst");

  // A write during a burst shows only after the lane goes idle
  property p_burst_defer;
    HS_BURST && hs_wr ##1 HS_BURST [*2] |-> HS_EXIT_APPLIED == $past(HS_EXIT_APPLIED, 2);
  endproperty
  a_burst_defer: assert property (p_burst_defer)
    else $error("exit write applied inside burst");

  // Unmapped access answers with an error, mapped ones do not
  property p_slverr;
    PSEL && PENABLE |-> PREADY && (PSLVERR == !(chk_hs_addr || chk_plx_addr));
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("bus error answer wrong");

  // Setup phase alone never writes a register
  property p_no_setup_write;
    PSEL && !PENABLE |=> $stable(hs_exit_override_en) && $stable(plx_override_en);
  endproperty
  a_no_setup_write: assert property (p_no_setup_write)
    else $error("register changed by setup phase");

  // Reset puts both registers back in auto mode; checked while reset is held
  property p_reset_state;
    disable iff (1'b0)
    RST |=> !hs_exit_override_en && !plx_override_en && PRDATA == `CPT_RST_RDATA
            && HS_EXIT_APPLIED == `CPT_RST_HS_VAL && PLX_APPLIED == `CPT_RST_PLX_VAL;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset wrong");

  // Clearing the override bit hands the exit interval back to auto
  property p_hs_ov_clear;
    chk_access_wr && chk_hs_addr && !PWDATA[`CPT_OV_BIT] |=> !hs_exit_override_en;
  endproperty
  a_hs_ov_clear: assert property (p_hs_ov_clear)
    else $error("exit override not cleared by write");

  // Tplx write with the override bit clear keeps the stored value and clears the override
  property p_plx_ro_write;
    chk_access_wr && chk_plx_addr && !PWDATA[`CPT_OV_BIT] |=> $stable(plx_value) && !plx_override_en;
  endproperty
  a_plx_ro_write: assert property (p_plx_ro_write)
    else $error("Tplx value changed by write with override clear");

  // Tplx read with the override set returns the stored value
  property p_plx_ov_read;
    chk_setup_rd && chk_plx_addr && plx_override_en
      |=> PRDATA == {{(`CPT_DATA_W-`CPT_REG_W){1'b0}}, 1'b1, $past(plx_value)};
  endproperty
  a_plx_ov_read: assert property (p_plx_ov_read)
    else $error("Tplx field write not read back");

  // A write without the lane 0 strobe touches nothing
  property p_strobe_refuse;
    PSEL && PENABLE && PWRITE && !PSTRB[0]
      |=> $stable(hs_exit_override_en) && $stable(hs_exit_value)
          && $stable(plx_override_en) && $stable(plx_value);
  endproperty
  a_strobe_refuse: assert property (p_strobe_refuse)
    else $error("register changed by write without strobe");

  // Unmapped reads return zero rather than stale data
  property p_unmapped_read;
    chk_setup_rd && !chk_hs_addr && !chk_plx_addr |=> PRDATA == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  // Read data moves only at a read setup edge, so it stands through the access
  property p_prdata_hold;
    !chk_setup_rd |=> $stable(PRDATA);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed outside a read setup");

  // Upper bytes carry no register bits and stay zero
  property p_prdata_upper;
    PRDATA[`CPT_DATA_W-1:`CPT_REG_W] == '0;
  endproperty
  a_prdata_upper: assert property (p_prdata_upper)
    else $error("read data upper bytes not zero");

endmodule // cpt_timing_regs

`default_nettype wire

// ### include/cpt_consts.svh
// Constants for the CSI timing override register pair
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH

// ==========================================================
// Register indices and byte addresses
`define CPT_ADDR_W        12
`define CPT_IDX_HS_EXIT   8'h47
`define CPT_IDX_PLX       8'h48
`define CPT_ADDR_HS_EXIT  {2'b00, `CPT_IDX_HS_EXIT, 2'b00}
`define CPT_ADDR_PLX      {2'b00, `CPT_IDX_PLX, 2'b00}

// ==========================================================
// Field layout
`define CPT_OV_BIT        7
`define CPT_VAL_MSB       6
`define CPT_VAL_W         7
`define CPT_REG_W         8
`define CPT_DATA_W        32

// ==========================================================
// Reset values
`define CPT_RST_OV        1'b0
`define CPT_RST_HS_VAL    7'h00
`define CPT_RST_PLX_VAL   7'h00
`define CPT_RST_RDATA     32'h0000_0000

`endif

// ### include/cpt_pkg.sv
// Types shared by the CSI timing override registers
`include "cpt_consts.svh"

package cpt_pkg;

  // ==========================================================
  // Types
  typedef logic [`CPT_VAL_W-1:0] cpt_val_t;
  typedef logic [`CPT_REG_W-1:0] cpt_byte_t;

  // One-hot register select
  typedef enum logic [2:0] {
    CPT_SEL_NONE = 3'h1,
    CPT_SEL_HS   = 3'h2,
    CPT_SEL_PLX  = 3'h4
  } cpt_sel_e;

endpackage : cpt_pkg

// ### include/cpt_regbus_if.sv
// Internal carrier between the bus slave and the register fields
`timescale 1ns/1ps
`default_nettype none

interface cpt_regbus_if;
  import cpt_pkg::*;

  // ==========================================================
  // Decoded access
  cpt_sel_e  sel;
  logic      wr_en;
  cpt_byte_t wdata;
  cpt_byte_t rdata;

  modport bus  (output sel, output wr_en, output wdata, input rdata);
  modport regs (input sel, input wr_en, input wdata, output rdata);
endinterface : cpt_regbus_if

`default_nettype wire

// ### test/cpt_timing_regs_test.sv
// Self-checking bench for the CSI timing override register pair
`timescale 1ns/1ps
`default_nettype none
`include "cpt_consts.svh"

module cpt_timing_regs_test
  import cpt_pkg::*;
;
  // ==========================================================
  // Stimulus and observation signals
  logic                   SYS_CLK;
  logic                   RST;
  logic                   PSEL;
  logic                   PENABLE;
  logic                   PWRITE;
  logic [`CPT_ADDR_W-1:0] PADDR;
  logic [`CPT_DATA_W-1:0] PWDATA;
  logic [3:0]             PSTRB;
  logic [`CPT_DATA_W-1:0] PRDATA;
  logic                   PREADY;
  logic                   PSLVERR;
  cpt_val_t               AUTO_HS_EXIT;
  cpt_val_t               AUTO_PLX;
  logic                   HS_BURST;
  cpt_val_t               HS_EXIT_APPLIED;
  cpt_val_t               PLX_APPLIED;
  int                     n_fail;
  int                     cmp_count;
  int                     cycles;
  logic [31:0]            rnd;
  logic [32:0]            exp_q[$];
  cpt_val_t               v;

  cpt_timing_regs dut_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .AUTO_HS_EXIT(AUTO_HS_EXIT), .AUTO_PLX(AUTO_PLX),
    .HS_BURST(HS_BURST), .HS_EXIT_APPLIED(HS_EXIT_APPLIED), .PLX_APPLIED(PLX_APPLIED)
  );

  // ==========================================================
  // Clock, 10 ns period
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [`CPT_ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] exp);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    if (!wr) begin
      exp_q.push_back(exp);
    end
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Idle edges so the lane side samples the register state
  task automatic settle_check(input cpt_val_t hs, input cpt_val_t plx);
    repeat (3) @(posedge SYS_CLK);
    #1;
    check("hs_applied", {26'h0, HS_EXIT_APPLIED}, {26'h0, hs});
    check("plx_applied", {26'h0, PLX_APPLIED}, {26'h0, plx});
  endtask

  // ==========================================================
  // Read monitor: oldest note against the completed read
  always @(posedge SYS_CLK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && PWRITE === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected_read", 33'h0, 33'h1_ffff_ffff);
      end else begin
        check("read_word", {PSLVERR, PRDATA}, exp_q.pop_front());
      end
    end
  end

  // Hang guard; the tests need well under 3000 cycles
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = '0;
    PWDATA = '0; PSTRB = 4'h0; AUTO_HS_EXIT = '0; AUTO_PLX = '0; HS_BURST = 1'b0;
    n_fail = 0; cmp_count = 0; cycles = 0; rnd = 32'h62f8_1852;
    repeat (12) @(posedge SYS_CLK);
    RST <= 1'b0;
    // Auto mode: reads follow the live input, writes to the field bounce off
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      AUTO_HS_EXIT <= rnd[6:0];
      AUTO_PLX     <= rnd[14:8];
      apb(1'b1, `CPT_ADDR_HS_EXIT, {24'h0, 1'b0, ~rnd[6:0]}, 4'hf, 33'h0);
      apb(1'b0, `CPT_ADDR_HS_EXIT, 32'h0, 4'h0, {26'h0, rnd[6:0]});
      apb(1'b0, `CPT_ADDR_PLX, 32'h0, 4'h0, {26'h0, rnd[14:8]});
      settle_check(rnd[6:0], rnd[14:8]);
    end
    $display("test auto_mode done");
    // Override mode: field writable, lane uses the programmed value
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, `CPT_ADDR_HS_EXIT, {24'h0, 1'b1, rnd[6:0]}, 4'h1, 33'h0);
      apb(1'b1, `CPT_ADDR_PLX, {24'h0, 1'b1, rnd[22:16]}, 4'h1, 33'h0);
      AUTO_HS_EXIT <= ~rnd[6:0];
      AUTO_PLX     <= ~rnd[22:16];
      apb(1'b0, `CPT_ADDR_HS_EXIT, 32'h0, 4'h0, {25'h0, 1'b1, rnd[6:0]});
      apb(1'b0, `CPT_ADDR_PLX, 32'h0, 4'h0, {25'h0, 1'b1, rnd[22:16]});
      settle_check(rnd[6:0], rnd[22:16]);
    end
    $display("test override_mode done");
    // Burst freeze: changes wait for the lane to go idle
    apb(1'b1, `CPT_ADDR_HS_EXIT, 32'h0000_00a0, 4'h1, 33'h0);
    apb(1'b1, `CPT_ADDR_PLX, 32'h0000_0080, 4'h1, 33'h0);
    settle_check(7'h20, 7'h00);
    @(posedge SYS_CLK);
    HS_BURST <= 1'b1;
    apb(1'b1, `CPT_ADDR_HS_EXIT, 32'h0000_0085, 4'h1, 33'h0);
    apb(1'b1, `CPT_ADDR_PLX, 32'h0000_0000, 4'h1, 33'h0);
    v = AUTO_PLX;
    settle_check(7'h20, 7'h00);
    @(posedge SYS_CLK);
    HS_BURST <= 1'b0;
    settle_check(7'h05, v);
    $display("test burst_freeze done");
    // Refusals: unmapped address, write without lane 0 strobe
    apb(1'b1, 12'h124, 32'h0000_00ff, 4'hf, 33'h0);
    apb(1'b0, 12'h124, 32'h0, 4'h0, {1'b1, 32'h0});
    apb(1'b1, `CPT_ADDR_HS_EXIT, 32'h0000_00ff, 4'he, 33'h0);
    apb(1'b0, `CPT_ADDR_HS_EXIT, 32'h0, 4'h0, {25'h0, 1'b1, 7'h05});
    settle_check(7'h05, v);
    $display("test refusals done");
    // Reset mid-run returns both registers to auto mode
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    apb(1'b0, `CPT_ADDR_HS_EXIT, 32'h0, 4'h0, {26'h0, AUTO_HS_EXIT});
    apb(1'b0, `CPT_ADDR_PLX, 32'h0, 4'h0, {26'h0, AUTO_PLX});
    settle_check(AUTO_HS_EXIT, AUTO_PLX);
    $display("test second_reset done");
    repeat (2) @(posedge SYS_CLK);
    check("reads_left", {1'b0, 32'(exp_q.size())}, 33'h0);
    conclude();
  end
endmodule // cpt_timing_regs_test

`default_nettype wire
